/* verilog/tmrc_pkg.sv */
// constants and types for the timer/counter block
package tmrc_pkg;
  // sfr addresses
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW = 8'h8A;
  localparam logic [7:0] ADDR_T1_LOW = 8'h8B;
  localparam logic [7:0] ADDR_T0_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_T1_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_T2_CTRL = 8'hC8;
  localparam logic [7:0] ADDR_T2_MODE = 8'hC9;
  // timer_mode_reg fields
  localparam int GATE1 = 7;
  localparam int CT1 = 6;
  localparam int M1_LO = 4;
  localparam int GATE0 = 3;
  localparam int CT0 = 2;
  localparam int M0_LO = 0;
  // timer_ctrl_reg fields
  localparam int T1_OVF = 7;
  localparam int T1_RUN = 6;
  localparam int T0_OVF = 5;
  localparam int T0_RUN = 4;
  // timer2_control fields
  localparam int T2_OVF = 7;
  localparam int T2_EXT = 6;
  localparam int RX_SEL = 5;
  localparam int TX_SEL = 4;
  localparam int TRIG_EN = 3;
  localparam int T2_RUN = 2;
  localparam int CT2 = 1;
  localparam int CPRL2 = 0;
  // timer2_mode_control fields
  localparam int OE2 = 1;
  localparam int DOWN_EN = 0;
  // reset values and the all-ones count
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_T2_MODE = 2'h0;
  localparam logic [15:0] ALL_ONES16 = 16'hFFFF;
  typedef enum logic [1:0] {
    TM_13BIT = 2'b00, TM_16BIT = 2'b01, TM_8RELOAD = 2'b10, TM_SPLIT = 2'b11
  } tmrc_tmode_t;
  typedef enum logic [2:0] {
    T2_OFF = 3'b000, T2_RELOAD = 3'b001, T2_CAPTURE = 3'b010,
    T2_CLKOUT = 3'b011, T2_BAUD = 3'b100
  } tmrc_t2mode_t;
endpackage

/* verilog/tmrc_timers.sv */
// two general timers plus third-timer control, mode decode and flags
// Function
// (R1) mode 0 counts with all high byte bits plus low five low byte bits
// (R2) overflow from all ones to zero sets the timer overflow flag
// (R3) counting only when run bit set and gate clear or int pin high
// (R4) setting run bit does not clear the count bytes
// (R5) pin-qualify bits are mode register bit 7 (timer 1), bit 3 (timer 0)
// (R6) mode 1 is mode 0 with full sixteen bits
// (R7) mode 2 low byte counts, reloads from high byte on overflow
// (R8) timer 1 in mode 3 holds count as if run bit cleared
// (R9) timer 0 mode 3 low byte is an 8-bit timer with timer 0 controls
// (R10) timer 0 mode 3 high byte counts cycles, uses timer 1 run and flag
// (R11) timer 1 still runs for baud; own mode 3 stops it
// (R12) third timer is 16-bit; select 0 machine cycles, 1 pin falling edges; here select 0 counts every clock in baud
// (R13) third timer mode: off, baud, capture, clock-out, or auto-reload
// (R14) third overflow flag set on overflow, not in baud or clock-out
// (R15) enabled trigger falling edge sets external flag in capture/reload/baud; here not in reload with up/down counting enabled
// (R16) rx and tx clock selects pick third timer or timer 1 overflows
// (R17) enabled trigger edges capture or reload, except while clocking uart
// (R18) capture select picks capture or reload; uart selects force reload
// (R19) third timer runs only while its run bit is 1
// (R20) mode reg bit 1 enables clock out, bit 0 enables up/down counting
// (R21) software writes zero to reserved mode reg bits 7 to 2
// (R22) counter pins sampled once per machine cycle, high then low counts
// (R23) two-bit mode fields select modes 0 to 3
// (R24) flags set and reloads applied in the wrapping cycle
`timescale 1ns/1ps
module tmrc_timers
  import tmrc_pkg::*;
(
  // clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_clk_en,
  input wire logic i_mc_tick,
  // special function register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  output logic [7:0] o_sfr_rdata,
  // pins
  input wire logic i_t0_pin,
  input wire logic i_t1_pin,
  input wire logic i_t2_pin,
  input wire logic i_ext_int0_pin,
  input wire logic i_ext_int1_pin,
  input wire logic i_trigger_pin,
  // third timer datapath
  input wire logic [15:0] i_t2_reload_value,
  output logic o_t2_capture,
  output logic [15:0] o_t2_count,
  // events and flags
  output logic o_t0_irq,
  output logic o_t1_irq,
  output logic o_t2_irq,
  output logic o_t1_overflow,
  output logic o_t2_overflow,
  output logic o_uart_rx_clk,
  output logic o_uart_tx_clk,
  output logic o_clock_out_en
);
  import tmrc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] mode_q, mode_d, t0lo_q, t0lo_d, t0hi_q, t0hi_d, t1lo_q, t1lo_d;
  logic [7:0] t1hi_q, t1hi_d, t2ctl_q, t2ctl_d, rdata_q, rdata_d;
  logic [3:0] ctrl_q, ctrl_d;
  logic [1:0] t2md_q, t2md_d;
  logic [15:0] t2cnt_q, t2cnt_d;
  logic [3:0] smp_q, smp_d;
  logic [2:0] evt_q, evt_d;
  logic [3:0] fall;
  tmrc_tmode_t m0, m1;
  tmrc_t2mode_t t2m;
  logic inc0, inc1, inc0h, ovf0, ovf1, ovf0h, baud, t2_inc, down, ovf2, trig_ev;
  logic [16:0] s0, s1;

  // one count step; bit 16 flags the wrap
  function automatic logic [16:0] step(input tmrc_tmode_t m, input logic [7:0] tl,
                                       input logic [7:0] th);
    logic [16:0] r;
    logic [12:0] c13;
    r = {1'b0, th, tl};
    c13 = 13'({th, tl[4:0]} + 13'h1);
    unique case (m)
      TM_13BIT:
      begin
        r[16] = (th == 8'hFF) && (tl[4:0] == 5'h1F); // see (R1) (R2)
        r[15:8] = c13[12:5];
        r[4:0] = c13[4:0];
      end
      TM_16BIT: r = 17'({th, tl}) + 17'h1; // see (R6)
      TM_8RELOAD:
      begin
        r[16] = (tl == 8'hFF);
        r[7:0] = r[16] ? th : 8'(tl + 8'h1); // see (R7) (R24)
      end
      TM_SPLIT:
      begin
        r[16] = (tl == 8'hFF);
        r[7:0] = 8'(tl + 8'h1); // see (R9)
      end
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    // pins sampled once per machine cycle; high then low is one edge
    smp_d = i_mc_tick ? {i_trigger_pin, i_t2_pin, i_t1_pin, i_t0_pin} : smp_q;
    fall = {4{i_mc_tick}} & smp_q & ~smp_d; // see (R22) (R12)
    m0 = tmrc_tmode_t'(mode_q[M0_LO+:2]); // see (R23)
    m1 = tmrc_tmode_t'(mode_q[M1_LO+:2]);
    inc0 = ctrl_q[T0_RUN - 4] && (!mode_q[GATE0] || i_ext_int0_pin) // see (R3) (R5)
           && (mode_q[CT0] ? fall[0] : i_mc_tick);
    // timer 1 loses its run bit to the high byte of timer 0 in split mode
    inc1 = (m1 != TM_SPLIT) // see (R8) (R11)
           && (m0 == TM_SPLIT || (ctrl_q[T1_RUN - 4] && (!mode_q[GATE1] || i_ext_int1_pin)))
           && (mode_q[CT1] ? fall[1] : i_mc_tick);
    inc0h = (m0 == TM_SPLIT) && ctrl_q[T1_RUN - 4] && i_mc_tick; // see (R10)
    s0 = step(m0, t0lo_q, t0hi_q);
    s1 = step(m1, t1lo_q, t1hi_q);
    ovf0 = inc0 && s0[16];
    ovf1 = inc1 && s1[16];
    ovf0h = inc0h && (t0hi_q == 8'hFF);
    // run bit only gates pulses, count bytes stay as they were
    t0lo_d = inc0 ? s0[7:0] : t0lo_q; // see (R4)
    t0hi_d = (m0 == TM_SPLIT) ? (inc0h ? 8'(t0hi_q + 8'h1) : t0hi_q) : (inc0 ? s0[15:8] : t0hi_q);
    t1lo_d = inc1 ? s1[7:0] : t1lo_q;
    t1hi_d = inc1 ? s1[15:8] : t1hi_q;
    // third timer mode decode
    baud = t2ctl_q[RX_SEL] || t2ctl_q[TX_SEL];
    if (!t2ctl_q[T2_RUN])
      t2m = T2_OFF; // see (R19)
    else if (baud)
      t2m = T2_BAUD; // see (R13)
    else if (t2ctl_q[CPRL2])
      t2m = T2_CAPTURE;
    else if (t2md_q[OE2])
      t2m = T2_CLKOUT; // see (R20)
    else
      t2m = T2_RELOAD;
    // baud generation counts oscillator cycles instead of machine cycles
    t2_inc = (t2m != T2_OFF) && (t2ctl_q[CT2] ? fall[2] : (baud || i_mc_tick)); // see (R12)
    down = t2md_q[DOWN_EN] && (t2m == T2_RELOAD) && !i_trigger_pin; // see (R20)
    ovf2 = t2_inc && (t2cnt_q == (down ? i_t2_reload_value : ALL_ONES16));
    // in up/down counting the trigger pin is the direction, not an event
    trig_ev = t2ctl_q[TRIG_EN] && fall[3] && (t2m inside {T2_CAPTURE, T2_RELOAD, T2_BAUD})
              && !(t2md_q[DOWN_EN] && t2m == T2_RELOAD); // see (R15) (R17)
    t2cnt_d = t2cnt_q;
    if (ovf2)
      t2cnt_d = down ? ALL_ONES16 : ((t2m == T2_CAPTURE) ? 16'h0000 : i_t2_reload_value);
    else if (t2_inc)
      t2cnt_d = down ? 16'(t2cnt_q - 16'h1) : 16'(t2cnt_q + 16'h1);
    if (trig_ev && t2m == T2_RELOAD)
      t2cnt_d = i_t2_reload_value; // see (R17) (R18)
    evt_d = {trig_ev && t2m == T2_CAPTURE, ovf2, ovf1}; // see (R18)
    // flags: hardware set wins over a software write in the same cycle
    ctrl_d = ctrl_q;
    t2ctl_d = t2ctl_q;
    mode_d = mode_q;
    t2md_d = t2md_q;
    if (i_sfr_wr)
    begin
      unique case (i_sfr_addr)
        ADDR_TIMER_CTRL: ctrl_d = i_sfr_wdata[7:4];
        ADDR_TIMER_MODE: mode_d = i_sfr_wdata;
        ADDR_T0_LOW: t0lo_d = i_sfr_wdata;
        ADDR_T0_HIGH: t0hi_d = i_sfr_wdata;
        ADDR_T1_LOW: t1lo_d = i_sfr_wdata;
        ADDR_T1_HIGH: t1hi_d = i_sfr_wdata;
        ADDR_T2_CTRL: t2ctl_d = i_sfr_wdata;
        ADDR_T2_MODE: t2md_d = i_sfr_wdata[1:0]; // see (R21)
        default: ;
      endcase
    end
    if (ovf0)
      ctrl_d[T0_OVF - 4] = 1'b1; // see (R2) (R9) (R24)
    if (ovf0h || (ovf1 && m0 != TM_SPLIT))
      ctrl_d[T1_OVF - 4] = 1'b1; // see (R10)
    if (ovf2 && !baud && t2m != T2_CLKOUT)
      t2ctl_d[T2_OVF] = 1'b1; // see (R14)
    if (trig_ev)
      t2ctl_d[T2_EXT] = 1'b1; // see (R15)
    rdata_d = rdata_q;
    if (i_sfr_rd)
    begin
      unique case (i_sfr_addr)
        ADDR_TIMER_CTRL: rdata_d = {ctrl_q, 4'h0};
        ADDR_TIMER_MODE: rdata_d = mode_q;
        ADDR_T0_LOW: rdata_d = t0lo_q;
        ADDR_T0_HIGH: rdata_d = t0hi_q;
        ADDR_T1_LOW: rdata_d = t1lo_q;
        ADDR_T1_HIGH: rdata_d = t1hi_q;
        ADDR_T2_CTRL: rdata_d = t2ctl_q;
        ADDR_T2_MODE: rdata_d = {6'h00, t2md_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      mode_q <= RST_BYTE;
      ctrl_q <= 4'h0;
      t0lo_q <= RST_BYTE;
      t0hi_q <= RST_BYTE;
      t1lo_q <= RST_BYTE;
      t1hi_q <= RST_BYTE;
      t2ctl_q <= RST_BYTE;
      t2md_q <= RST_T2_MODE;
      t2cnt_q <= 16'h0000;
      smp_q <= 4'h0;
      evt_q <= 3'h0;
      rdata_q <= RST_BYTE;
    end
    else if (i_clk_en)
    begin
      mode_q <= mode_d;
      ctrl_q <= ctrl_d;
      t0lo_q <= t0lo_d;
      t0hi_q <= t0hi_d;
      t1lo_q <= t1lo_d;
      t1hi_q <= t1hi_d;
      t2ctl_q <= t2ctl_d;
      t2md_q <= t2md_d;
      t2cnt_q <= t2cnt_d;
      smp_q <= smp_d;
      evt_q <= evt_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign o_sfr_rdata = rdata_q;
  assign o_t0_irq = ctrl_q[T0_OVF - 4];
  assign o_t1_irq = ctrl_q[T1_OVF - 4];
  assign o_t2_irq = t2ctl_q[T2_OVF] || t2ctl_q[T2_EXT];
  assign o_t1_overflow = evt_q[0];
  assign o_t2_overflow = evt_q[1];
  assign o_t2_capture = evt_q[2];
  assign o_t2_count = t2cnt_q;
  assign o_uart_rx_clk = t2ctl_q[RX_SEL] ? evt_q[1] : evt_q[0]; // see (R16)
  assign o_uart_tx_clk = t2ctl_q[TX_SEL] ? evt_q[1] : evt_q[0]; // see (R16)
  assign o_clock_out_en = t2md_q[OE2] && !t2ctl_q[CT2];

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  sequence t0_wrap_s;
    i_clk_en && !i_sfr_wr && m0 == TM_16BIT && inc0 && t0lo_q == 8'hFF && t0hi_q == 8'hFF;
  endsequence
  sequence t0_cleared_s;
    ctrl_q[T0_OVF - 4] && t0lo_q == 8'h00 && t0hi_q == 8'h00;
  endsequence

  a_run_off_hold: assert property (i_clk_en && !ctrl_q[T0_RUN - 4] && m0 != TM_SPLIT // see (R3)
    && !(i_sfr_wr && i_sfr_addr == ADDR_T0_LOW) |=> $stable(t0lo_q))
    else $error("timer 0 low byte moved with run bit clear");
  // split mode excluded: there the high byte follows the timer 1 run bit instead
  a_gate_pin_low: assert property (i_clk_en && mode_q[GATE0] && !i_ext_int0_pin // see (R5)
    && m0 != TM_SPLIT && !i_sfr_wr |=> $stable({t0hi_q, t0lo_q}))
    else $error("timer 0 counted while gate pin low");
  a_wrap_sets_flag: assert property (t0_wrap_s |=> t0_cleared_s) // see (R2)
    else $error("16-bit wrap did not clear count and set flag");
  a_reload_high_byte: assert property (i_clk_en && !i_sfr_wr && m1 == TM_8RELOAD // see (R7)
    && m0 != TM_SPLIT && inc1 && t1lo_q == 8'hFF
    |=> t1lo_q == $past(t1hi_q) && ctrl_q[T1_OVF - 4])
    else $error("mode 2 reload or flag missing");
  a_t1_split_hold: assert property (i_clk_en && m1 == TM_SPLIT && !i_sfr_wr // see (R8)
    |=> $stable({t1hi_q, t1lo_q}))
    else $error("timer 1 counted in mode 3");
  a_baud_no_flag: assert property (i_clk_en && baud && !t2ctl_q[T2_OVF] && !i_sfr_wr // see (R14)
    |=> !t2ctl_q[T2_OVF])
    else $error("third overflow flag set while clocking uart");
  a_flag_sticky: assert property (t2ctl_q[T2_OVF] // see (R14)
    && !(i_sfr_wr && i_sfr_addr == ADDR_T2_CTRL) |=> t2ctl_q[T2_OVF])
    else $error("third overflow flag cleared without a write");
  a_trigger_flag: assert property (i_clk_en && trig_ev |=> t2ctl_q[T2_EXT] // see (R15)
    ##0 (t2m != T2_CAPTURE || o_t2_capture))
    else $error("trigger edge lost");
  a_t2_off_hold: assert property (i_clk_en && !t2ctl_q[T2_RUN] |=> $stable(t2cnt_q)) // see (R19)
    else $error("third timer counted while stopped");
endmodule

/* bench/tmrc_pin_model.sv */
// pin model for the count, gate and trigger inputs
`timescale 1ns/1ps
module tmrc_pin_model (
  // clock and machine tick
  input wire logic i_ref_clk,
  input wire logic i_mc_tick,
  // bench asks for a low level per pin
  input wire logic [5:0] i_low_req,
  // pins: t0, t1, t2, int0, int1, trigger
  output logic [5:0] o_pins
);
  // idle level is high, as the port pins carry pull-ups
  initial o_pins = 6'h3F;
  // levels move only on a machine tick, so each is held a full cycle
  always @(posedge i_ref_clk)
  begin
    if (i_mc_tick)
    begin
      o_pins <= ~i_low_req;
    end
  end
endmodule

/* bench/test_tmrc_timers.sv */
// self-checking bench for the timer/counter block
`timescale 1ns/1ps
module test_tmrc_timers;
  import tmrc_pkg::*;
  logic clk = 0, srst = 1, tck = 0, wr = 0, rd = 0, cen = 1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
  logic [5:0] low_req = 6'h00, pins;
  logic [15:0] rel = 16'hFFFE, t2cnt, c0;
  logic t0_irq, t1_irq, t2_irq, t1_ov, t2_ov, rx_clk, tx_clk, cap, clk_oe;
  int bad_count = 0, comparisons = 0, cycles = 0, tx_pulses = 0, cap_pulses = 0;
  int rx_pulses = 0, ov_pulses = 0;
  logic [7:0] th_in [3] = '{8'hFF, 8'hFF, 8'h55};
  logic [7:0] tl_in [3] = '{8'h1F, 8'hFF, 8'hFF};
  logic [7:0] msk [3] = '{8'h1F, 8'hFF, 8'hFF};
  logic [7:0] ex [3] = '{8'h00, 8'h00, 8'h55};
  always #2.5 clk = ~clk;
  tmrc_pin_model pm (.i_ref_clk(clk), .i_mc_tick(tck), .i_low_req(low_req), .o_pins(pins));
  tmrc_timers dut (.i_ref_clk(clk), .i_srst(srst), .i_clk_en(cen), .i_mc_tick(tck),
    .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata), .i_sfr_rd(rd), .o_sfr_rdata(rdata),
    .i_t0_pin(pins[0]), .i_t1_pin(pins[1]), .i_t2_pin(pins[2]), .i_ext_int0_pin(pins[3]),
    .i_ext_int1_pin(pins[4]), .i_trigger_pin(pins[5]), .i_t2_reload_value(rel),
    .o_t2_capture(cap), .o_t2_count(t2cnt), .o_t0_irq(t0_irq), .o_t1_irq(t1_irq),
    .o_t2_irq(t2_irq), .o_t1_overflow(t1_ov), .o_t2_overflow(t2_ov), .o_uart_rx_clk(rx_clk),
    .o_uart_tx_clk(tx_clk), .o_clock_out_en(clk_oe));
  ////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // each task starts and ends on a rising edge; the trailing edge keeps strobes apart
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    @(posedge clk);
  endtask
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      tck <= 1;
      @(posedge clk);
      tck <= 0;
      @(posedge clk);
    end
  endtask
  // the run needs about 66000 cycles, mostly the first third-timer wrap
  always @(posedge clk)
  begin
    cycles++;
    if (tx_clk === 1'b1) tx_pulses++;
    if (cap === 1'b1) cap_pulses++;
    if (rx_clk === 1'b1) rx_pulses++;
    if (t2_ov === 1'b1) ov_pulses++;
    if (cycles == 90000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    foreach (ex[i])
    begin
      rd8(i == 0 ? ADDR_T2_CTRL : i == 1 ? ADDR_T2_MODE : 8'h80, v);
      chk(v, 8'h00);
    end
    wr8(ADDR_T2_MODE, 8'h03);
    rd8(ADDR_T2_MODE, v);
    chk(v, 8'h03);
    chk(clk_oe, 1'b1);
    wr8(ADDR_T2_MODE, 8'h00);
    foreach (ex[i])
    begin
      wr8(ADDR_TIMER_CTRL, 8'h00);
      wr8(ADDR_TIMER_MODE, 8'(i));
      wr8(ADDR_T0_HIGH, th_in[i]);
      wr8(ADDR_T0_LOW, tl_in[i]);
      wr8(ADDR_TIMER_CTRL, 8'h10);
      rd8(ADDR_T0_LOW, v);
      chk(v, tl_in[i]);
      chk(t0_irq, 1'b0);
      tick(1);
      rd8(ADDR_T0_HIGH, v);
      chk(v, i == 2 ? th_in[i] : ex[i]);
      rd8(ADDR_T0_LOW, v);
      chk(v & msk[i], ex[i]);
      chk(t0_irq, 1'b1);
    end
    // gate closed by a low int0 pin, then opened
    wr8(ADDR_TIMER_CTRL, 8'h00);
    wr8(ADDR_TIMER_MODE, 8'h09);
    wr8(ADDR_T0_LOW, 8'h00);
    low_req <= 6'h08;
    tick(1);
    wr8(ADDR_TIMER_CTRL, 8'h10);
    tick(2);
    rd8(ADDR_T0_LOW, v);
    chk(v, 8'h00);
    low_req <= 6'h00;
    tick(2);
    rd8(ADDR_T0_LOW, v);
    chk(v, 8'h01);
    // counter function on a falling t0 pin
    wr8(ADDR_TIMER_MODE, 8'h05);
    wr8(ADDR_T0_LOW, 8'h00);
    low_req <= 6'h01;
    tick(4);
    rd8(ADDR_T0_LOW, v);
    chk(v, 8'h01);
    low_req <= 6'h00;
    // both timers in mode 3
    wr8(ADDR_TIMER_CTRL, 8'h00);
    wr8(ADDR_TIMER_MODE, 8'h33);
    wr8(ADDR_T1_LOW, 8'h00);
    wr8(ADDR_T0_HIGH, 8'hFE);
    wr8(ADDR_TIMER_CTRL, 8'h40);
    tick(2);
    rd8(ADDR_T0_HIGH, v);
    chk(v, 8'h00);
    chk(t1_irq, 1'b1);
    rd8(ADDR_T1_LOW, v);
    chk(v, 8'h00);
    // baud generator: counts every clock, no overflow flag
    wr8(ADDR_T2_CTRL, 8'h14);
    repeat (70000) if (tx_pulses < 4) @(posedge clk);
    chk(tx_pulses >= 4, 1'b1);
    chk(ov_pulses >= 4, 1'b1);
    // receive select left at 0 follows timer 1, which is held in its mode 3
    chk(rx_pulses, 0);
    rd8(ADDR_T2_CTRL, v);
    chk(v & 8'h80, 8'h00);
    wr8(ADDR_T2_CTRL, 8'h04);
    tick(2);
    rd8(ADDR_T2_CTRL, v);
    chk(v & 8'h80, 8'h80);
    chk(t2_irq, 1'b1);
    // trigger edge ignored, then flagged and captured on the same edge
    wr8(ADDR_T2_CTRL, 8'h04);
    low_req <= 6'h20;
    tick(2);
    rd8(ADDR_T2_CTRL, v);
    chk(v & 8'h40, 8'h00);
    low_req <= 6'h00;
    tick(1);
    wr8(ADDR_T2_CTRL, 8'h0D);
    low_req <= 6'h20;
    tick(2);
    rd8(ADDR_T2_CTRL, v);
    chk(v & 8'h40, 8'h40);
    chk(cap_pulses, 1);
    low_req <= 6'h00;
    // clock enable low freezes a running third timer
    cen <= 1'b0;
    c0 = t2cnt;
    tick(3);
    chk(t2cnt, c0);
    cen <= 1'b1;
    wr8(ADDR_T2_CTRL, 8'h00);
    c0 = t2cnt;
    tick(3);
    chk(t2cnt, c0);
    end_of_test();
  end
endmodule
